// [event_input_function_select.sv]
// Event input function select: drives set point, gain set, alarm clears,
// output kills and parameter lock from one event input and a function code.
// Assumes the event input may be asynchronous to clock.
`timescale 1ns/10ps
module event_input_function_select (
  // Clock and reset
  input  wire logic                          clock,
  input  wire logic                          rst_b,
  // Avalon-MM slave
  input  wire logic [event_pkg::ADDR_W+1:0]  avAddress,
  input  wire logic                          avRead,
  input  wire logic                          avWrite,
  input  wire logic [31:0]                   avWritedata,
  input  wire logic [3:0]                    avByteenable,
  output logic      [31:0]                   avReaddata,
  output logic                               avWaitrequest,
  // Event input
  input  wire logic                          eventIn,
  // Tuning engine
  input  wire logic                          tuneDone,
  input  wire logic [event_pkg::DATA_W-1:0]  tunePb,
  input  wire logic [event_pkg::DATA_W-1:0]  tuneTi,
  input  wire logic [event_pkg::DATA_W-1:0]  tuneTd,
  input  wire logic [event_pkg::DATA_W-1:0]  setpointSourceMode,
  // Alarm and output control
  input  wire logic                          alarm1Cond,
  input  wire logic                          alarm2Cond,
  input  wire logic [event_pkg::DATA_W-1:0]  out1DriveIn,
  input  wire logic [event_pkg::DATA_W-1:0]  out2DriveIn,
  output logic                               alarm1Clear,
  output logic                               alarm2Clear,
  output logic                               alarm1Retrigger,
  output logic                               alarm2Retrigger,
  output logic      [event_pkg::DATA_W-1:0]  out1DriveLevel,
  output logic      [event_pkg::DATA_W-1:0]  out2DriveLevel,
  output logic      [event_pkg::DATA_W-1:0]  activeSetpoint,
  output logic      [event_pkg::DATA_W-1:0]  activePb,
  output logic      [event_pkg::DATA_W-1:0]  activeTi,
  output logic      [event_pkg::DATA_W-1:0]  activeTd,
  output logic                               paramLocked
);
  import event_pkg::*;

  function automatic logic [DATA_W-1:0] pick(input logic sel, input logic [DATA_W-1:0] a,
                                             input logic [DATA_W-1:0] b);
    pick = sel ? b : a;
  endfunction : pick

  param_mem_if mif ();
  param_mem u_mem (
    .clock (clock),
    .port  (mif.mem)
  );

  // Event synchroniser; first stage feeds only the second
  logic evtS1_q, evtS2_q, evtPrev_q;
  logic evtS1_d, evtS2_d, evtPrev_d;
  logic evtRise, evtFall;
  always_comb begin
    evtS1_d   = eventIn;
    evtS2_d   = evtS1_q;
    evtPrev_d = evtS2_q;
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      evtS1_q   <= 1'b0;
      evtS2_q   <= 1'b0;
      evtPrev_q <= 1'b0;
    end else begin
      evtS1_q   <= evtS1_d;
      evtS2_q   <= evtS2_d;
      evtPrev_q <= evtPrev_d;
    end
  end
  assign evtRise = evtS2_q & ~evtPrev_q;
  assign evtFall = ~evtS2_q & evtPrev_q;

  // Configuration and parameter copies
  event_fn_e         func_q, func_d;
  logic              fmt_q, fmt_d;
  logic [DATA_W-1:0] sp1_q, sp2_q, pb1_q, ti1_q, td1_q, pb2_q, ti2_q, td2_q;
  logic [DATA_W-1:0] sp1_d, sp2_d, pb1_d, ti1_d, td1_d, pb2_d, ti2_d, td2_d;
  logic              useSp2, useGain2, lockNow, busWr;
  logic [ADDR_W-1:0] wIdx;
  logic [DATA_W-1:0] wVal;
  logic              memWe;
  logic [ADDR_W-1:0] memWaddr;
  logic [DATA_W-1:0] memWdata;

  assign wIdx = avAddress[ADDR_W+1:2];
  assign wVal = avWritedata[DATA_W-1:0];
  assign useSp2   = evtS2_q & (func_q == FN_SP2 || func_q == FN_SP_GAIN2);
  assign useGain2 = evtS2_q & (func_q == FN_GAIN2 || func_q == FN_SP_GAIN2);
  assign lockNow  = evtS2_q & (func_q == FN_LOCK);

  always_comb begin
    func_d = func_q;
    fmt_d  = fmt_q;
    sp1_d = sp1_q;
    sp2_d = sp2_q;
    pb1_d = pb1_q;
    ti1_d = ti1_q;
    td1_d = td1_q;
    pb2_d = pb2_q;
    ti2_d = ti2_q;
    td2_d = td2_q;
    memWe = 1'b0;
    memWaddr = wIdx;
    memWdata = wVal;
    busWr = avWrite & ~avWaitrequest & avByteenable[0] & avByteenable[1];
    if (busWr && !lockNow) begin
      memWe = 1'b1;
      case (wIdx)
        CTRL_IDX: begin
          memWe = 1'b0;
          // Codes above 10 are refused so exactly one behaviour holds
          if (avWritedata[CTRL_FUNC_LSB +: CTRL_FUNC_W] <= 4'ha) begin
            func_d = event_fn_e'(avWritedata[CTRL_FUNC_LSB +: CTRL_FUNC_W]);
          end
          fmt_d = avWritedata[CTRL_FMT_BIT];
        end
        SP1_IDX: sp1_d = wVal;
        SP2_IDX: sp2_d = wVal;
        PB1_IDX: pb1_d = wVal;
        TI1_IDX: ti1_d = wVal;
        TD1_IDX: td1_d = wVal;
        PB2_IDX: pb2_d = wVal;
        TI2_IDX: ti2_d = wVal;
        TD2_IDX: td2_d = wVal;
        default: memWe = 1'b0;
      endcase
    end else if (tuneDone) begin
      // Tuning results land in whichever set is in force; the lock guards only
      // operator writes, since tuning is a controller action
      if (useGain2) begin
        pb2_d = tunePb;
        ti2_d = tuneTi;
        td2_d = tuneTd;
      end else begin
        pb1_d = tunePb;
        ti1_d = tuneTi;
        td1_d = tuneTd;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      func_q <= FN_NONE;
      fmt_q  <= CTRL_RST[CTRL_FMT_BIT];
      sp1_q <= PARM_RST;
      sp2_q <= PARM_RST;
      pb1_q <= PARM_RST;
      ti1_q <= PARM_RST;
      td1_q <= PARM_RST;
      pb2_q <= PARM_RST;
      ti2_q <= PARM_RST;
      td2_q <= PARM_RST;
    end else begin
      func_q <= func_d;
      fmt_q  <= fmt_d;
      sp1_q <= sp1_d;
      sp2_q <= sp2_d;
      pb1_q <= pb1_d;
      ti1_q <= ti1_d;
      td1_q <= td1_d;
      pb2_q <= pb2_d;
      ti2_q <= ti2_d;
      td2_q <= td2_d;
    end
  end

  assign mif.we    = memWe;
  assign mif.waddr = memWaddr;
  assign mif.wdata = memWdata;
  assign mif.raddr = wIdx;

  // The store has no reset, so words not yet written since reset read back
  // their reset value; this also hides stale contents after a mid-run reset
  logic [NUM_WORDS-1:0] wordSet_q, wordSet_d;
  always_comb begin
    wordSet_d = wordSet_q;
    if (memWe) begin
      wordSet_d[memWaddr] = 1'b1;
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wordSet_q <= '0;
    end else begin
      wordSet_q <= wordSet_d;
    end
  end

  // Control outputs, all registered
  logic [DATA_W-1:0] sp2Eff, baseSp;
  logic [DATA_W-1:0] actSp_d, actPb_d, actTi_d, actTd_d, o1_d, o2_d;
  logic              a1c_d, a2c_d, a1r_d, a2r_d;
  logic              clrA1Fn, clrA2Fn, killO1, killO2;
  // Wraps on overflow; the operator keeps the sum in range
  assign sp2Eff = fmt_q ? DATA_W'(sp1_q + sp2_q) : sp2_q;
  // Whenever set point 2 is not in force, the source-mode set point replaces sp1 when one is offered
  assign baseSp = (setpointSourceMode != '0) ? setpointSourceMode : sp1_q;
  assign clrA1Fn = (func_q == FN_CLR_A1) || (func_q == FN_CLR_A12);
  assign clrA2Fn = (func_q == FN_CLR_A2) || (func_q == FN_CLR_A12);
  assign killO1 = evtS2_q & ((func_q == FN_KILL_O1) || (func_q == FN_KILL_O12));
  assign killO2 = evtS2_q & ((func_q == FN_KILL_O2) || (func_q == FN_KILL_O12));

  always_comb begin
    actSp_d = pick(useSp2, baseSp, sp2Eff);
    actPb_d = pick(useGain2, pb1_q, pb2_q);
    actTi_d = pick(useGain2, ti1_q, ti2_q);
    actTd_d = pick(useGain2, td1_q, td2_q);
    o1_d = killO1 ? '0 : out1DriveIn;
    o2_d = killO2 ? '0 : out2DriveIn;
    a1c_d = clrA1Fn & evtRise;
    a2c_d = clrA2Fn & evtRise;
    a1r_d = clrA1Fn & evtFall & alarm1Cond;
    a2r_d = clrA2Fn & evtFall & alarm2Cond;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      activeSetpoint  <= PARM_RST;
      activePb        <= PARM_RST;
      activeTi        <= PARM_RST;
      activeTd        <= PARM_RST;
      out1DriveLevel  <= PARM_RST;
      out2DriveLevel  <= PARM_RST;
      alarm1Clear     <= 1'b0;
      alarm2Clear     <= 1'b0;
      alarm1Retrigger <= 1'b0;
      alarm2Retrigger <= 1'b0;
      paramLocked     <= 1'b0;
    end else begin
      activeSetpoint  <= actSp_d;
      activePb        <= actPb_d;
      activeTi        <= actTi_d;
      activeTd        <= actTd_d;
      out1DriveLevel  <= o1_d;
      out2DriveLevel  <= o2_d;
      alarm1Clear     <= a1c_d;
      alarm2Clear     <= a2c_d;
      alarm1Retrigger <= a1r_d;
      alarm2Retrigger <= a2r_d;
      paramLocked     <= lockNow;
    end
  end

  // Bus slave: writes finish in one cycle, reads wait for registered data
  bus_state_e        bus_q, bus_d;
  logic [31:0]       rd_d;
  logic              wait_d;
  logic [DATA_W-1:0] stWord;
  assign stWord = DATA_W'({useSp2, useGain2, lockNow, evtS2_q});

  always_comb begin
    bus_d  = bus_q;
    rd_d   = avReaddata;
    wait_d = 1'b1;
    case (bus_q)
      BUS_IDLE: begin
        if (avWrite) begin
          wait_d = 1'b0;
          bus_d  = BUS_DONE;
        end else if (avRead) begin
          bus_d = BUS_RD;
        end
      end
      BUS_RD: begin
        case (wIdx)
          CTRL_IDX:   rd_d = {27'h0, fmt_q, func_q};
          STATUS_IDX: rd_d = {16'h0, stWord};
          ACT_SP_IDX: rd_d = {16'h0, activeSetpoint};
          ACT_PB_IDX: rd_d = {16'h0, activePb};
          ACT_TI_IDX: rd_d = {16'h0, activeTi};
          ACT_TD_IDX: rd_d = {16'h0, activeTd};
          default: begin
            if (wIdx < ADDR_W'(NUM_WORDS)) begin
              if (wordSet_q[wIdx]) begin
                rd_d = {16'h0, mif.rdata};
              end else begin
                rd_d = {16'h0, PARM_RST};
              end
            end else begin
              rd_d = UNMAPPED_RD;
            end
          end
        endcase
        wait_d = 1'b0;
        bus_d  = BUS_DONE;
      end
      BUS_DONE: bus_d = BUS_IDLE;
      default:  bus_d = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bus_q         <= BUS_IDLE;
      avReaddata    <= UNMAPPED_RD;
      avWaitrequest <= 1'b1;
    end else begin
      bus_q         <= bus_d;
      avReaddata    <= rd_d;
      avWaitrequest <= wait_d;
    end
  end
endmodule : event_input_function_select

// [event_pkg.sv]
// Package for the event input function block: register map, fields, resets.
// Assumes a 32-bit Avalon-MM slave with waitrequest and one 20 MHz clock.
package event_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 4;
  // Word indices; byte address is four times these
  localparam logic [ADDR_W-1:0] CTRL_IDX   = 4'h0;
  localparam logic [ADDR_W-1:0] SP1_IDX    = 4'h1;
  localparam logic [ADDR_W-1:0] SP2_IDX    = 4'h2;
  localparam logic [ADDR_W-1:0] PB1_IDX    = 4'h3;
  localparam logic [ADDR_W-1:0] TI1_IDX    = 4'h4;
  localparam logic [ADDR_W-1:0] TD1_IDX    = 4'h5;
  localparam logic [ADDR_W-1:0] PB2_IDX    = 4'h6;
  localparam logic [ADDR_W-1:0] TI2_IDX    = 4'h7;
  localparam logic [ADDR_W-1:0] TD2_IDX    = 4'h8;
  localparam logic [ADDR_W-1:0] STATUS_IDX = 4'h9;
  localparam logic [ADDR_W-1:0] ACT_SP_IDX = 4'ha;
  localparam logic [ADDR_W-1:0] ACT_PB_IDX = 4'hb;
  localparam logic [ADDR_W-1:0] ACT_TI_IDX = 4'hc;
  localparam logic [ADDR_W-1:0] ACT_TD_IDX = 4'hd;
  localparam int unsigned NUM_WORDS = 14;
  // Control fields
  localparam int unsigned CTRL_FUNC_LSB = 0;
  localparam int unsigned CTRL_FUNC_W   = 4;
  localparam int unsigned CTRL_FMT_BIT  = 4;
  // Status fields
  localparam int unsigned ST_EVENT_BIT = 0;
  localparam int unsigned ST_LOCK_BIT  = 1;
  localparam int unsigned ST_GAIN2_BIT = 2;
  localparam int unsigned ST_SP2_BIT   = 3;
  // Reset values
  localparam logic [DATA_W-1:0] CTRL_RST = 16'h0000;
  localparam logic [DATA_W-1:0] PARM_RST = 16'h0000;
  localparam logic [31:0]       UNMAPPED_RD = 32'h0000_0000;

  typedef enum logic [3:0] {
    FN_NONE      = 4'b0000,
    FN_SP2       = 4'b0001,
    FN_GAIN2     = 4'b0010,
    FN_SP_GAIN2  = 4'b0011,
    FN_CLR_A1    = 4'b0100,
    FN_CLR_A2    = 4'b0101,
    FN_CLR_A12   = 4'b0110,
    FN_KILL_O1   = 4'b0111,
    FN_KILL_O2   = 4'b1000,
    FN_KILL_O12  = 4'b1001,
    FN_LOCK      = 4'b1010
  } event_fn_e;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_RD   = 2'b01,
    BUS_DONE = 2'b10
  } bus_state_e;
endpackage : event_pkg

// [param_mem_if.sv]
// Carrier between the block top and its parameter store.
// Assumes a single clock; one write port and one registered read port.
`timescale 1ns/10ps
interface param_mem_if;
  import event_pkg::*;
  logic                we;
  logic [ADDR_W-1:0]   waddr;
  logic [DATA_W-1:0]   wdata;
  logic [ADDR_W-1:0]   raddr;
  logic [DATA_W-1:0]   rdata;
  modport user (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : param_mem_if

// [param_mem.sv]
// Small register-out memory holding set points and gain sets for bus reads.
// Assumes the top keeps its own live copies for control use.
`timescale 1ns/10ps
module param_mem (
  // Clock
  input wire logic     clock,
  // Access
  param_mem_if.mem     port
);
  import event_pkg::*;
  logic [DATA_W-1:0] store [NUM_WORDS];
  logic [DATA_W-1:0] rdata_d;

  always_comb begin
    rdata_d = store[port.raddr];
  end

  always_ff @(posedge clock) begin
    if (port.we) begin
      store[port.waddr] <= port.wdata;
    end
    port.rdata <= rdata_d;
  end
endmodule : param_mem

// [event_source_model.sv]
// Far-side model: a switch or open-collector source on the event input.
// Assumes the bench commands it; the level moves only just after a clock edge.
`timescale 1ns/10ps
module event_source_model (
  // Clock
  input  wire logic clock,
  // Command and contact level
  input  wire logic closeReq,
  output logic      eventIn
);
  // Edge-aligned so the latency seen by the bench stays fixed
  initial eventIn = 1'b0;
  always @(posedge clock) eventIn <= closeReq;
endmodule : event_source_model

// [event_input_function_select_sva.sv]
// Checker for the event function block: bus answers, event pulses, output gating.
// Assumes event effects lag the sampled input by three edges.
`timescale 1ns/10ps
module event_input_function_select_sva (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_b,
  // Bus
  input wire logic        avRead,
  input wire logic        avWaitrequest,
  input wire logic [31:0] avReaddata,
  // Event side
  input wire logic        eventIn,
  input wire logic [15:0] out1DriveIn,
  input wire logic [15:0] out2DriveIn,
  input wire logic [15:0] out1DriveLevel,
  input wire logic [15:0] out2DriveLevel,
  input wire logic        alarm1Clear,
  input wire logic        alarm2Clear,
  input wire logic        alarm1Retrigger,
  input wire logic        alarm2Retrigger,
  input wire logic        paramLocked
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_wait_one_cycle: assert property (!avWaitrequest |=> avWaitrequest) else $error("answer held too long");
  a_read_answered: assert property ($rose(avRead) |-> ##[1:3] !avWaitrequest) else $error("read unanswered");
  a_read_upper_zero: assert property (avRead && !avWaitrequest |-> avReaddata[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_clear_one_edge: assert property (alarm1Clear |-> $past(eventIn, 3) && !$past(eventIn, 4))
    else $error("alarm 1 clear off edge");
  a_clear_two_edge: assert property (alarm2Clear |-> $past(eventIn, 3) && !$past(eventIn, 4))
    else $error("alarm 2 clear off edge");
  a_retrig_one_release: assert property (alarm1Retrigger |-> !$past(eventIn, 3) && $past(eventIn, 4))
    else $error("alarm 1 retrigger off release");
  a_retrig_two_release: assert property (alarm2Retrigger |-> !$past(eventIn, 3) && $past(eventIn, 4))
    else $error("alarm 2 retrigger off release");
  a_clear_single_pulse: assert property (alarm1Clear |=> !alarm1Clear) else $error("clear pulse too long");
  a_lock_needs_event: assert property (paramLocked |-> $past(eventIn, 3)) else $error("lock without event");
  a_drive_one_gated: assert property (out1DriveLevel == 16'h0000 || out1DriveLevel == $past(out1DriveIn))
    else $error("output 1 level corrupt");
  a_drive_two_gated: assert property (out2DriveLevel == 16'h0000 || out2DriveLevel == $past(out2DriveIn))
    else $error("output 2 level corrupt");
  c_both_cleared: cover property (alarm1Clear && alarm2Clear);
  c_retriggered: cover property (alarm2Retrigger);
  c_locked: cover property ($rose(paramLocked));
endmodule : event_input_function_select_sva

bind event_input_function_select event_input_function_select_sva i_sva (
  .clock, .rst_b, .avRead, .avWaitrequest, .avReaddata, .eventIn, .out1DriveIn, .out2DriveIn,
  .out1DriveLevel, .out2DriveLevel, .alarm1Clear, .alarm2Clear, .alarm1Retrigger, .alarm2Retrigger,
  .paramLocked
);

// [event_input_function_select_bench.sv]
// Self-checking bench for the event function block.
// Assumes the bus timing and event latency given by the designer.
`timescale 1ns/10ps
module event_input_function_select_bench;
  import event_pkg::*;
  logic        clock = 0, rst_b = 0, avRead = 0, avWrite = 0, closeReq = 0, tuneDone = 0;
  logic        alarm1Cond = 0, alarm2Cond = 0, eventIn, avWaitrequest, paramLocked;
  logic        alarm1Clear, alarm2Clear, alarm1Retrigger, alarm2Retrigger;
  logic [5:0]  avAddress = 0;
  logic [3:0]  avByteenable = 4'hf;
  logic [31:0] avWritedata = 0, avReaddata;
  logic [15:0] tunePb = 0, tuneTi = 0, tuneTd = 0, setpointSourceMode = 0, out1DriveIn = 0, out2DriveIn = 0;
  logic [15:0] out1DriveLevel, out2DriveLevel, activeSetpoint, activePb, activeTi, activeTd;
  logic [31:0] rdQ[$];
  logic [3:0]  pulseQ[$];
  logic [15:0] p[16];
  int          failCount = 0, totalChecks = 0, seed = 32'h29c1fe01;

  always #25 clock = ~clock;

  event_source_model i_event_source_model (.clock, .closeReq, .eventIn);
  event_input_function_select i_event_input_function_select (
    .clock, .rst_b, .avAddress, .avRead, .avWrite, .avWritedata, .avByteenable, .avReaddata,
    .avWaitrequest, .eventIn, .tuneDone, .tunePb, .tuneTi, .tuneTd, .setpointSourceMode,
    .alarm1Cond, .alarm2Cond, .out1DriveIn, .out2DriveIn, .alarm1Clear, .alarm2Clear,
    .alarm1Retrigger, .alarm2Retrigger, .out1DriveLevel, .out2DriveLevel, .activeSetpoint,
    .activePb, .activeTi, .activeTd, .paramLocked
  );

  task automatic closeOut;
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : closeOut

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic checkRead(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: read got %h expected %h", $time, got, exp);
    end
  endtask : checkRead

  task automatic checkPulse(input logic [3:0] got, input logic [3:0] exp);
    totalChecks++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: pulses got %h expected %h", $time, got, exp);
    end
  endtask : checkPulse

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clock);
    avAddress <= {idx, 2'b00};
    avWrite <= wr;
    avRead <= !wr;
    avWritedata <= d;
    avByteenable <= be;
    // Waitrequest is read as it stood before each rising edge
    do begin
      @(posedge clock);
      n++;
    end while (avWaitrequest !== 1'b0 && n < 40);
    if (avWaitrequest !== 1'b0) begin
      failCount++;
      closeOut();
    end else begin
      avWrite <= 1'b0;
      avRead <= 1'b0;
    end
  endtask : bus

  task automatic wr(input logic [3:0] idx, input logic [15:0] d);
    bus(1'b1, idx, {16'h0000, d}, 4'hf);
  endtask : wr

  task automatic rd(input logic [3:0] idx, input logic [15:0] e);
    rdQ.push_back({16'h0000, e});
    bus(1'b0, idx, 32'h0000_0000, 4'hf);
  endtask : rd

  // Margin covers the contact model plus the three-edge event latency
  task automatic ev(input logic v);
    @(posedge clock);
    closeReq <= v;
    repeat (8) @(posedge clock);
  endtask : ev

  always @(negedge clock) begin
    if (avRead && avWaitrequest === 1'b0)
      checkRead(avReaddata, rdQ.size() ? rdQ.pop_front() : 32'hx);
    if ({alarm1Clear, alarm2Clear, alarm1Retrigger, alarm2Retrigger} !== 4'h0)
      checkPulse({alarm1Clear, alarm2Clear, alarm1Retrigger, alarm2Retrigger},
                 pulseQ.size() ? pulseQ.pop_front() : 4'hx);
  end

  initial begin
    repeat (20000) @(posedge clock);
    failCount++;
    closeOut();
  end

  initial begin
    logic [15:0] sp2;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    for (int i = 0; i < 16; i++) rd(i[3:0], 16'h0000);
    wr(4'hf, 16'hffff);
    rd(4'hf, 16'h0000);
    for (int i = 1; i < 9; i++) begin
      p[i] = 16'($random(seed));
      wr(i[3:0], p[i]);
      rd(i[3:0], p[i]);
    end
    for (int f = 0; f < 8; f++) begin
      setpointSourceMode <= f[1:0] == 2'b00 ? 16'($random(seed)) | 16'h0001 : 16'h0000;
      wr(CTRL_IDX, {11'h000, f[2], 2'b00, f[1:0]});
      ev(1'b1);
      sp2 = f[2] ? p[1] + p[2] : p[2];
      cmp(activeSetpoint, f[0] ? sp2 : (f[1:0] == 2'b00 ? setpointSourceMode : p[1]));
      cmp(activePb, f[1] ? p[6] : p[3]);
      cmp(activeTd, f[1] ? p[8] : p[5]);
      ev(1'b0);
      cmp(activeSetpoint, f[1:0] == 2'b00 ? setpointSourceMode : p[1]);
    end
    wr(CTRL_IDX, 16'h0002);
    ev(1'b1);
    tuneDone <= 1'b1;
    tunePb <= 16'($random(seed));
    tuneTi <= 16'($random(seed));
    @(posedge clock);
    tuneDone <= 1'b0;
    repeat (3) @(posedge clock);
    cmp(activePb, tunePb);
    cmp(activeTi, tuneTi);
    ev(1'b0);
    cmp(activePb, p[3]);
    for (int f = 4; f < 7; f++) begin
      wr(CTRL_IDX, f[15:0]);
      for (int k = 0; k < 4; k++) begin
        alarm1Cond <= k[0];
        alarm2Cond <= k[1];
        pulseQ.push_back({f != 5, f != 4, 2'b00});
        ev(1'b1);
        if ((f != 5 && k[0]) || (f != 4 && k[1]))
          pulseQ.push_back({2'b00, f != 5 && k[0], f != 4 && k[1]});
        ev(1'b0);
      end
    end
    for (int f = 7; f < 10; f++) begin
      wr(CTRL_IDX, f[15:0]);
      out1DriveIn <= 16'($random(seed)) | 16'h0001;
      out2DriveIn <= 16'($random(seed)) | 16'h0001;
      ev(1'b1);
      cmp(out1DriveLevel, f == 8 ? out1DriveIn : 16'h0000);
      cmp(out2DriveLevel, f == 7 ? out2DriveIn : 16'h0000);
      ev(1'b0);
      cmp(out1DriveLevel, out1DriveIn);
      cmp(out2DriveLevel, out2DriveIn);
    end
    wr(CTRL_IDX, 16'h000a);
    ev(1'b1);
    cmp(paramLocked, 1'b1);
    wr(SP1_IDX, ~p[1]);
    wr(CTRL_IDX, 16'h0001);
    rd(SP1_IDX, p[1]);
    rd(CTRL_IDX, 16'h000a);
    rd(STATUS_IDX, 16'h0003);
    ev(1'b0);
    cmp(paramLocked, 1'b0);
    bus(1'b1, SP1_IDX, 32'h0000_1234, 4'h2);
    wr(CTRL_IDX, 16'h001b);
    rd(SP1_IDX, p[1]);
    rd(CTRL_IDX, 16'h001a);
    repeat (4) @(posedge clock);
    cmp(rdQ.size() + pulseQ.size(), 0);
    closeOut();
  end
endmodule : event_input_function_select_bench
